// file: shared/sfpi_defs.svh
`ifndef SFPI_DEFS_SVH
`define SFPI_DEFS_SVH

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define SFPI_CLK_NS     40
`define SFPI_TRST_NS    1000
`define SFPI_RST_CYC    ((`SFPI_TRST_NS + `SFPI_CLK_NS - 1) / `SFPI_CLK_NS)

// ----------------------------------------------------------------
// synchroniser vector layout and reset value, lane enable codes, idle byte and buffer depth
// ----------------------------------------------------------------
`define SFPI_CS_BIT     0
`define SFPI_CLK_BIT    1
`define SFPI_RSTN_BIT   2
`define SFPI_SYNC_RST   7'h04
`define SFPI_OE_OFF     4'hf
`define SFPI_OE_SINGLE  4'hd
`define SFPI_OE_DUAL    4'hc
`define SFPI_OE_QUAD    4'h0
`define SFPI_IDLE_BYTE  8'hff
`define SFPI_BUF_DEPTH  2

`endif

// file: shared/sfpi_pkg.sv
package sfpi_pkg;

   // lane width of a phase
   typedef enum logic [1:0] {
      W_SINGLE = 2'b00,
      W_DUAL   = 2'b01,
      W_QUAD   = 2'b10
   } sfpi_width_type;

   // frame state
   typedef enum logic [1:0] {
      ST_IDLE  = 2'b00,
      ST_INSTR = 2'b01,
      ST_PHASE = 2'b10,
      ST_HALT  = 2'b11
   } sfpi_state_type;

   // phase setting given by the instruction decoder
   typedef struct packed {
      logic           dirOut;
      sfpi_width_type width;
   } sfpi_phase_type;

   // received byte
   typedef struct packed {
      logic       isInstr;
      logic [7:0] data;
   } sfpi_rx_type;

endpackage : sfpi_pkg

// file: hdl/sfpi_pair_buffer.sv
`timescale 1ns/10ps
`default_nettype none
`include "sfpi_defs.svh"

module sfpi_pair_buffer (
   // system
   input  wire logic                   mclk,
   input  wire logic                   rst,
   // filling side
   input  wire logic                   inValid,
   input  wire sfpi_pkg::sfpi_rx_type  inWord,
   output logic                        inReady,
   // draining side
   output logic                        outValid,
   output var sfpi_pkg::sfpi_rx_type   outWord,
   input  wire logic                   outReady
);

   sfpi_pkg::sfpi_rx_type word_ff  [`SFPI_BUF_DEPTH];
   sfpi_pkg::sfpi_rx_type nxt_word [`SFPI_BUF_DEPTH];
   logic [1:0]            valid_ff;
   logic [1:0]            nxt_valid;

   // head always sits in entry 0 so the outputs come straight from flops
   always_comb begin
      nxt_valid = valid_ff;
      nxt_word  = word_ff;
      if (outReady && valid_ff[0]) begin
         nxt_word[0] = word_ff[1];
         nxt_valid   = {1'b0, valid_ff[1]};
      end
      // refuse while full even if popping; costs a cycle, keeps ready a flop bit
      if (inValid && !valid_ff[1]) begin
         if (nxt_valid[0]) begin
            nxt_word[1]  = inWord;
            nxt_valid[1] = 1'b1;
         end else begin
            nxt_word[0]  = inWord;
            nxt_valid[0] = 1'b1;
         end
      end
   end

   // registers; data needs no reset, valid bits do
   always_ff @(posedge mclk) begin
      word_ff <= nxt_word;
      if (rst) begin
         valid_ff <= 2'b00;
      end else begin
         valid_ff <= nxt_valid;
      end
   end

   assign inReady  = ~valid_ff[1];
   assign outValid = valid_ff[0];
   assign outWord  = word_ff[0];

endmodule : sfpi_pair_buffer
`default_nettype wire

// file: hdl/sfpi_pin_front.sv
`timescale 1ns/10ps
`default_nettype none
`include "sfpi_defs.svh"

module sfpi_pin_front (
   // system
   input  wire logic                     mclk,
   input  wire logic                     rst,
   // pins from the host
   input  wire logic                     csN,
   input  wire logic                     sclk,
   input  wire logic                     resetPinN,
   input  wire logic [3:0]               dataLineIn,
   // pins toward the host, enable low while driving
   output logic [3:0]                    dataLineOut,
   output logic [3:0]                    dataLineOeN,
   // core side control
   input  wire sfpi_pkg::sfpi_phase_type phaseCfg,
   input  wire logic                     quadLinesEnable,
   input  wire logic                     intBusy,
   input  wire logic                     txValid,
   input  wire logic [7:0]               txByte,
   output logic                          txTaken,
   // received bytes
   output logic                          rxValid,
   output var sfpi_pkg::sfpi_rx_type     rxWord,
   input  wire logic                     rxReady,
   // status
   output logic                          selected,
   output logic                          deviceIdle,
   output logic                          coreReset,
   output logic                          overrun
);

   localparam logic [4:0] RST_LAST = 5'(`SFPI_RST_CYC - 1);

   // ----------------------------------------------------------------
   // pin synchronisers
   // ----------------------------------------------------------------
   logic [6:0] meta_ff;
   logic [6:0] sync_ff;
   logic [6:0] prev_ff;
   logic [6:0] nxt_meta;
   logic [6:0] nxt_sync;
   logic [6:0] nxt_prev;

   // first stage feeds only the second; edges come from stages two and three
   always_comb begin
      nxt_meta = {dataLineIn, resetPinN, sclk, csN};
      nxt_sync = meta_ff;
      nxt_prev = sync_ff;
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         meta_ff <= `SFPI_SYNC_RST;
         sync_ff <= `SFPI_SYNC_RST;
         prev_ff <= `SFPI_SYNC_RST;
      end else begin
         meta_ff <= nxt_meta;
         sync_ff <= nxt_sync;
         prev_ff <= nxt_prev;
      end
   end

   logic       csHigh;
   logic       csFall;
   logic       clkRise;
   logic       clkFall;
   logic       pinHigh;
   logic [3:0] lines;

   // the sync reset value reads chip select low, so a pin held low from
   // power-up never looks like a falling edge
   assign csHigh  = sync_ff[`SFPI_CS_BIT];
   assign csFall  = prev_ff[`SFPI_CS_BIT] & ~sync_ff[`SFPI_CS_BIT];
   assign clkRise = sync_ff[`SFPI_CLK_BIT] & ~prev_ff[`SFPI_CLK_BIT];
   assign clkFall = prev_ff[`SFPI_CLK_BIT] & ~sync_ff[`SFPI_CLK_BIT];
   assign pinHigh = sync_ff[`SFPI_RSTN_BIT];
   assign lines   = sync_ff[6:3];

   // ----------------------------------------------------------------
   // hardware reset pin
   // ----------------------------------------------------------------
   logic [4:0] lowCnt_ff;
   logic [4:0] nxt_lowCnt;
   logic       coreReset_ff;
   logic       nxt_coreReset;
   logic       rstAll;

   // nothing gates this counter but the system reset, so no state masks it
   always_comb begin
      nxt_lowCnt = 5'h00;
      if (!pinHigh) begin
         nxt_lowCnt = (lowCnt_ff == RST_LAST) ? lowCnt_ff : lowCnt_ff + 5'h01;
      end
      nxt_coreReset = !pinHigh && (lowCnt_ff == RST_LAST);
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         lowCnt_ff    <= 5'h00;
         coreReset_ff <= 1'b0;
      end else begin
         lowCnt_ff    <= nxt_lowCnt;
         coreReset_ff <= nxt_coreReset;
      end
   end

   assign rstAll = rst | coreReset_ff;

   // ----------------------------------------------------------------
   // frame engine
   // ----------------------------------------------------------------
   sfpi_pkg::sfpi_state_type state_ff;
   sfpi_pkg::sfpi_state_type nxt_state;
   sfpi_pkg::sfpi_phase_type phase_ff;
   sfpi_pkg::sfpi_phase_type nxt_phase;
   sfpi_pkg::sfpi_width_type curW;
   sfpi_pkg::sfpi_rx_type    pushWord;
   logic [2:0] bitCnt_ff;
   logic [2:0] nxt_bitCnt;
   logic [2:0] outLeft_ff;
   logic [2:0] nxt_outLeft;
   logic [2:0] lastChunk;
   logic [7:0] shIn_ff;
   logic [7:0] nxt_shIn;
   logic [7:0] shOut_ff;
   logic [7:0] nxt_shOut;
   logic [7:0] src;
   logic [3:0] dqOut_ff;
   logic [3:0] nxt_dqOut;
   logic [3:0] oeN_ff;
   logic [3:0] nxt_oeN;
   logic [3:0] step;
   logic [3:0] sum;
   logic       armed_ff;
   logic       nxt_armed;
   logic       selected_ff;
   logic       nxt_selected;
   logic       idle_ff;
   logic       nxt_idle;
   logic       overrun_ff;
   logic       nxt_overrun;
   logic       txTaken_ff;
   logic       nxt_txTaken;
   logic       byteDone;
   logic       push;
   logic       bufReady;

   // instruction bytes always single line, later phases follow the decoder
   always_comb begin
      curW = (state_ff == sfpi_pkg::ST_PHASE) ? phase_ff.width : sfpi_pkg::W_SINGLE;
      case (curW)
         sfpi_pkg::W_DUAL: step = 4'h2;
         sfpi_pkg::W_QUAD: step = 4'h4;
         default:          step = 4'h1;
      endcase
      sum         = {1'b0, bitCnt_ff} + step;
      byteDone    = clkRise && (sum == 4'h8);
      nxt_state   = state_ff;
      nxt_bitCnt  = bitCnt_ff;
      nxt_shIn    = shIn_ff;
      nxt_phase   = phase_ff;
      nxt_outLeft = outLeft_ff;
      nxt_shOut   = shOut_ff;
      nxt_dqOut   = dqOut_ff;
      nxt_txTaken = 1'b0;
      nxt_armed   = armed_ff | csHigh;
      push        = 1'b0;
      lastChunk   = 3'h7;
      src         = (outLeft_ff == 3'h0) ? (txValid ? txByte : `SFPI_IDLE_BYTE) : shOut_ff;
      case (state_ff)
         sfpi_pkg::ST_IDLE: begin
            if (csFall && armed_ff) begin
               nxt_state  = sfpi_pkg::ST_INSTR;
               nxt_bitCnt = 3'h0;
            end
         end
         sfpi_pkg::ST_INSTR, sfpi_pkg::ST_PHASE: begin
            // sample on rising edge
            if (clkRise) begin
               nxt_bitCnt = sum[2:0];
               case (curW)
                  sfpi_pkg::W_DUAL: nxt_shIn = {shIn_ff[5:0], lines[1:0]};
                  sfpi_pkg::W_QUAD: nxt_shIn = {shIn_ff[3:0], lines};
                  default:          nxt_shIn = {shIn_ff[6:0], lines[0]};
               endcase
            end
            // each byte boundary takes the decoder's next phase setting
            if (byteDone) begin
               push        = (state_ff == sfpi_pkg::ST_INSTR) || !phase_ff.dirOut;
               nxt_phase   = phaseCfg;
               nxt_outLeft = 3'h0;
               if (phaseCfg.width == sfpi_pkg::W_QUAD && !quadLinesEnable) begin
                  nxt_state = sfpi_pkg::ST_HALT;
               end else begin
                  nxt_state = sfpi_pkg::ST_PHASE;
               end
            end
            // drive on falling edge, new byte fetched when the old one ran out
            if (clkFall && state_ff == sfpi_pkg::ST_PHASE && phase_ff.dirOut) begin
               nxt_txTaken = (outLeft_ff == 3'h0) && txValid;
               case (curW)
                  sfpi_pkg::W_DUAL: begin
                     nxt_dqOut = {2'b00, src[7:6]};
                     nxt_shOut = {src[5:0], 2'b00};
                     lastChunk = 3'h3;
                  end
                  sfpi_pkg::W_QUAD: begin
                     nxt_dqOut = src[7:4];
                     nxt_shOut = {src[3:0], 4'h0};
                     lastChunk = 3'h1;
                  end
                  default: begin
                     nxt_dqOut = {2'b00, src[7], 1'b0};
                     nxt_shOut = {src[6:0], 1'b0};
                     lastChunk = 3'h7;
                  end
               endcase
               nxt_outLeft = (outLeft_ff == 3'h0) ? lastChunk : outLeft_ff - 3'h1;
            end
         end
         sfpi_pkg::ST_HALT: begin
            nxt_state = sfpi_pkg::ST_HALT;   // refused quad frame: wait for deselect
         end
         default: begin
            nxt_state = sfpi_pkg::ST_IDLE;
         end
      endcase
      if (csHigh) begin
         nxt_state  = sfpi_pkg::ST_IDLE;
         nxt_bitCnt = 3'h0;
      end
      nxt_selected = (nxt_state != sfpi_pkg::ST_IDLE);
      nxt_oeN      = `SFPI_OE_OFF;
      if (nxt_state == sfpi_pkg::ST_PHASE && nxt_phase.dirOut) begin
         case (nxt_phase.width)
            sfpi_pkg::W_DUAL: nxt_oeN = `SFPI_OE_DUAL;
            sfpi_pkg::W_QUAD: nxt_oeN = `SFPI_OE_QUAD;
            default:          nxt_oeN = `SFPI_OE_SINGLE;
         endcase
      end
      nxt_idle    = csHigh && !intBusy;
      // a fresh overrun wins over the clear at frame start
      nxt_overrun = (push && !bufReady) || (overrun_ff && !(csFall && armed_ff));
      pushWord.isInstr = (state_ff == sfpi_pkg::ST_INSTR);
      pushWord.data    = nxt_shIn;
   end

   always_ff @(posedge mclk) begin
      if (rstAll) begin
         state_ff    <= sfpi_pkg::ST_IDLE;
         phase_ff    <= '0;
         bitCnt_ff   <= 3'h0;
         outLeft_ff  <= 3'h0;
         shIn_ff     <= 8'h00;
         shOut_ff    <= 8'h00;
         dqOut_ff    <= 4'h0;
         oeN_ff      <= `SFPI_OE_OFF;
         armed_ff    <= 1'b0;
         selected_ff <= 1'b0;
         idle_ff     <= 1'b0;
         overrun_ff  <= 1'b0;
         txTaken_ff  <= 1'b0;
      end else begin
         state_ff    <= nxt_state;
         phase_ff    <= nxt_phase;
         bitCnt_ff   <= nxt_bitCnt;
         outLeft_ff  <= nxt_outLeft;
         shIn_ff     <= nxt_shIn;
         shOut_ff    <= nxt_shOut;
         dqOut_ff    <= nxt_dqOut;
         oeN_ff      <= nxt_oeN;
         armed_ff    <= nxt_armed;
         selected_ff <= nxt_selected;
         idle_ff     <= nxt_idle;
         overrun_ff  <= nxt_overrun;
         txTaken_ff  <= nxt_txTaken;
      end
   end

   // ----------------------------------------------------------------
   // receive buffer: the serial link cannot stall, a full buffer drops
   // the byte and raises overrun instead
   // ----------------------------------------------------------------
   sfpi_pair_buffer u_buf (
      .mclk     (mclk),
      .rst      (rstAll),
      .inValid  (push),
      .inWord   (pushWord),
      .inReady  (bufReady),
      .outValid (rxValid),
      .outWord  (rxWord),
      .outReady (rxReady)
   );

   assign dataLineOut = dqOut_ff;
   assign dataLineOeN = oeN_ff;
   assign txTaken     = txTaken_ff;
   assign selected    = selected_ff;
   assign deviceIdle  = idle_ff;
   assign coreReset   = coreReset_ff;
   assign overrun     = overrun_ff;

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rstAll);

   property p_deselHiZ;
      !selected_ff |-> oeN_ff == `SFPI_OE_OFF;
   endproperty
   a_deselHiZ: assert property (p_deselHiZ) else $error("lines driven while deselected");

   property p_selOnFall;
      (state_ff == sfpi_pkg::ST_IDLE) && csFall && armed_ff |=> selected_ff;
   endproperty
   a_selOnFall: assert property (p_selOnFall) else $error("no select on cs fall");

   property p_notArmed;
      !armed_ff |=> !selected_ff;
   endproperty
   a_notArmed: assert property (p_notArmed) else $error("selected before first cs edge");

   property p_instrEight;
      (state_ff == sfpi_pkg::ST_INSTR) && clkRise && (bitCnt_ff == 3'h7) && !csHigh
         |=> state_ff != sfpi_pkg::ST_INSTR;
   endproperty
   a_instrEight: assert property (p_instrEight) else $error("instruction not 8 bits");

   property p_quadLanes;
      (state_ff == sfpi_pkg::ST_PHASE) && phase_ff.dirOut && (phase_ff.width == sfpi_pkg::W_QUAD)
         |-> oeN_ff == `SFPI_OE_QUAD;
   endproperty
   a_quadLanes: assert property (p_quadLanes) else $error("quad lanes not driven");

   property p_busyNotIdle;
      intBusy |=> !deviceIdle;
   endproperty
   a_busyNotIdle: assert property (p_busyNotIdle) else $error("idle while busy");

   property p_pinReset;
      @(posedge mclk) disable iff (rst)
      (!pinHigh && lowCnt_ff == RST_LAST) |=> coreReset_ff ##1 !selected_ff;
   endproperty
   a_pinReset: assert property (p_pinReset) else $error("pin reset not taken");

   property p_stillNoEdge;
      (state_ff == sfpi_pkg::ST_PHASE) && !clkFall |=> $stable(dqOut_ff);
   endproperty
   a_stillNoEdge: assert property (p_stillNoEdge) else $error("output moved early");

   property p_quadGate;
      byteDone && !csHigh && (phaseCfg.width == sfpi_pkg::W_QUAD) && !quadLinesEnable
         |=> state_ff == sfpi_pkg::ST_HALT ##1 oeN_ff == `SFPI_OE_OFF;
   endproperty
   a_quadGate: assert property (p_quadGate) else $error("quad honoured without enable");

   property p_csEnds;
      csHigh |=> (state_ff == sfpi_pkg::ST_IDLE) && (bitCnt_ff == 3'h0);
   endproperty
   a_csEnds: assert property (p_csEnds) else $error("frame not ended by cs");

   c_instrDone: cover property (state_ff == sfpi_pkg::ST_INSTR ##1 state_ff == sfpi_pkg::ST_PHASE);
   c_quadRead: cover property (oeN_ff == `SFPI_OE_QUAD ##1 txTaken_ff);
   c_overrun: cover property ($rose(overrun_ff));
   c_pinReset: cover property (@(posedge mclk) disable iff (rst) $rose(coreReset_ff));

endmodule : sfpi_pin_front
`default_nettype wire

// file: testbench/sfpi_host_model.sv
`timescale 1ns/10ps
`default_nettype none

// ----------------------------------------------------------------
// host controller model
// ----------------------------------------------------------------
module sfpi_host_model (
   // system
   input  wire logic       mclk,
   // link toward the device
   output logic            csN,
   output logic            sclk,
   output logic [3:0]      hostOut,
   output logic [3:0]      hostOe,
   input  wire logic [3:0] lineLevel
);
   // select starts low, so a frame without a fresh fall must be ignored
   initial begin
      csN     = 1'b0;
      sclk    = 1'b0;
      hostOut = 4'h0;
      hostOe  = 4'h0;
   end

   // clock rests low in mode 0 and high in mode 3 at select edges
   task automatic select(input bit m3);
      sclk <= m3;
      repeat (4) @(posedge mclk);
      csN <= 1'b0;
      repeat (8) @(posedge mclk);
   endtask : select

   task automatic deselect(input bit m3);
      sclk <= m3;
      repeat (4) @(posedge mclk);
      csN    <= 1'b1;
      hostOe <= 4'h0;
      repeat (8) @(posedge mclk);
   endtask : deselect

   // one byte, msb first, half period 4 mclk; lanes read late in high phase
   task automatic shift(input int lanes, input bit drv, input logic [7:0] txb,
                        output logic [7:0] rxb);
      logic [3:0] mask;
      int         sh;
      mask = 4'((1 << lanes) - 1);
      rxb  = 8'h00;
      for (int s = 0; s < 8 / lanes; s++) begin
         sh = 8 - lanes * (s + 1);
         sclk    <= 1'b0;
         hostOe  <= drv ? mask : 4'h0;
         hostOut <= 4'(txb >> sh) & mask;
         repeat (4) @(posedge mclk);
         sclk <= 1'b1;
         repeat (4) @(posedge mclk);
         rxb = rxb | (8'(lanes == 1 ? {3'h0, lineLevel[1]} : lineLevel & mask) << sh);
      end
   endtask : shift
endmodule : sfpi_host_model

`default_nettype wire

// file: testbench/sfpi_pin_front_tb_top.sv
`timescale 1ns/10ps
`default_nettype none

module sfpi_pin_front_tb_top;
   // ----------------------------------------------------------------
   // signals
   // ----------------------------------------------------------------
   logic                     mclk = 1'b0;
   logic                     rst;
   logic                     resetPinN;
   logic                     quadLinesEnable;
   logic                     intBusy;
   logic                     txValid;
   logic [7:0]               txByte;
   logic                     rxReady;
   logic                     toggle = 1'b0;
   sfpi_pkg::sfpi_phase_type phaseCfg;
   sfpi_pkg::sfpi_rx_type    rxWord;
   sfpi_pkg::sfpi_rx_type    rxQ[$];
   logic [3:0]               hostOut, hostOe, lineLevel, dataLineOut, dataLineOeN;
   logic                     csN, sclk, txTaken, rxValid, selected, deviceIdle;
   logic                     coreReset, overrun;
   int                       miscompares = 0, n_checks = 0, nTaken = 0, seed = 31;

   always #20 mclk = ~mclk;
   // released lanes flip each cycle so a stale level never passes for data
   always_ff @(posedge mclk) toggle <= ~toggle;
   assign lineLevel = (~dataLineOeN & dataLineOut) | (dataLineOeN & hostOe & hostOut)
                    | (dataLineOeN & ~hostOe & {toggle, ~toggle, toggle, ~toggle});
   // receiver side of the buffer and send pulse counting
   always @(posedge mclk) begin
      if (rxValid === 1'b1 && rxReady === 1'b1) rxQ.push_back(rxWord);
      if (txTaken === 1'b1) nTaken++;
   end

   sfpi_host_model sfpi_host_model_i (.mclk(mclk), .csN(csN), .sclk(sclk), .hostOut(hostOut),
      .hostOe(hostOe), .lineLevel(lineLevel));
   sfpi_pin_front sfpi_pin_front_i (.mclk(mclk), .rst(rst), .csN(csN), .sclk(sclk),
      .resetPinN(resetPinN), .dataLineIn(lineLevel), .dataLineOut(dataLineOut),
      .dataLineOeN(dataLineOeN), .phaseCfg(phaseCfg), .quadLinesEnable(quadLinesEnable),
      .intBusy(intBusy), .txValid(txValid), .txByte(txByte), .txTaken(txTaken),
      .rxValid(rxValid), .rxWord(rxWord), .rxReady(rxReady), .selected(selected),
      .deviceIdle(deviceIdle), .coreReset(coreReset), .overrun(overrun));

   // ----------------------------------------------------------------
   // checking
   // ----------------------------------------------------------------
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      n_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("Error at %0t ns: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic final_report();
      $display("checks %0d, mismatches %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : final_report

   // an empty queue counts as a mismatch
   task automatic popCheck(input logic [8:0] exp);
      check(rxQ.size() > 0 ? 16'(rxQ.pop_front()) : 16'hffff, 16'(exp));
   endtask : popCheck

   // enables of a device-driven phase: single drives line 1 only
   function automatic logic [3:0] oeFor(input sfpi_pkg::sfpi_width_type w);
      return (w == sfpi_pkg::W_SINGLE) ? 4'hd : (w == sfpi_pkg::W_DUAL) ? 4'hc : 4'h0;
   endfunction : oeFor

   task automatic waitCyc(input int n);
      repeat (n) @(posedge mclk);
   endtask : waitCyc

   // one frame: instruction on lane 0, then one byte in the chosen phase
   task automatic op(input bit m3, input logic dir, input sfpi_pkg::sfpi_width_type w,
                     input bit qe);
      logic [7:0] ins, dat, got;
      bit         ok;
      ins = 8'($random(seed));
      dat = 8'($random(seed));
      ok  = qe || w != sfpi_pkg::W_QUAD;
      phaseCfg        <= '{dirOut: dir, width: w};
      quadLinesEnable <= qe;
      nTaken = 0;
      sfpi_host_model_i.select(m3);
      check(16'(selected), 16'h1);
      sfpi_host_model_i.shift(1, 1'b1, ins, got);
      txByte  <= dat;
      txValid <= dir;
      sfpi_host_model_i.shift(1 << int'(w), !dir, dat, got);
      txValid <= 1'b0;
      waitCyc(6);
      check(16'(rxQ.size()), 16'((!dir && ok) ? 2 : 1));
      popCheck({1'b1, ins});
      if (!dir && ok) popCheck({1'b0, dat});
      check(16'(dataLineOeN), 16'((dir && ok) ? oeFor(w) : 4'hf));
      if (dir && ok) check(16'(got), 16'(dat));
      if (dir) check(16'(nTaken), 16'(ok));
      check(16'(selected), 16'h1);
      sfpi_host_model_i.deselect(m3);
      check(16'(dataLineOeN), 16'hf);
      check(16'(selected), 16'h0);
      rxQ.delete();
   endtask : op

   // ----------------------------------------------------------------
   // tests
   // ----------------------------------------------------------------
   initial begin
      waitCyc(40000);
      miscompares++;
      final_report();
   end

   initial begin
      logic [7:0] b, got;
      // idle levels before the first edge; reset spans three edges
      rst             <= 1'b1;
      resetPinN       <= 1'b1;
      quadLinesEnable <= 1'b1;
      intBusy         <= 1'b0;
      txValid         <= 1'b0;
      txByte          <= 8'h00;
      rxReady         <= 1'b1;
      phaseCfg        <= '0;
      waitCyc(3);
      rst <= 1'b0;
      check(16'(dataLineOeN), 16'hf);
      waitCyc(4);
      b = 8'($random(seed));
      sfpi_host_model_i.shift(1, 1'b1, b, got);
      waitCyc(6);
      check(16'(rxQ.size()), 16'h0);
      sfpi_host_model_i.deselect(1'b0);
      $display("test unarmed frame done");
      // every width and direction, quad also with the enable cleared
      for (int k = 0; k < 16; k++) begin
         op(1'($random(seed)), 1'(k), sfpi_pkg::sfpi_width_type'((k % 8) < 6 ? (k % 8) >> 1 : 2),
            (k % 8) < 6);
      end
      $display("test phase table done");
      phaseCfg        <= '0;
      quadLinesEnable <= 1'b1;
      // four bits then deselect: the next frame must start from bit 7
      sfpi_host_model_i.select(1'b0);
      sfpi_host_model_i.shift(2, 1'b1, 8'hff, got);
      sfpi_host_model_i.deselect(1'b0);
      b = 8'($random(seed));
      sfpi_host_model_i.select(1'b1);
      sfpi_host_model_i.shift(1, 1'b1, b, got);
      waitCyc(6);
      sfpi_host_model_i.deselect(1'b1);
      check(16'(rxQ.size()), 16'h1);
      popCheck({1'b1, b});
      $display("test cut frame done");
      // receiver stalls: third byte is dropped, first two kept
      rxReady <= 1'b0;
      sfpi_host_model_i.select(1'b0);
      for (int k = 0; k < 3; k++) sfpi_host_model_i.shift(1, 1'b1, 8'(k), got);
      waitCyc(6);
      check(16'(overrun), 16'h1);
      rxReady <= 1'b1;
      waitCyc(4);
      sfpi_host_model_i.deselect(1'b0);
      check(16'(rxQ.size()), 16'h2);
      popCheck({1'b1, 8'h00});
      popCheck({1'b0, 8'h01});
      sfpi_host_model_i.select(1'b0);
      check(16'(overrun), 16'h0);
      sfpi_host_model_i.deselect(1'b0);
      $display("test buffer full done");
      intBusy <= 1'b1;
      waitCyc(4);
      check(16'(deviceIdle), 16'h0);
      intBusy <= 1'b0;
      waitCyc(4);
      check(16'(deviceIdle), 16'h1);
      $display("test busy done");
      // pin reset in mid read with a cycle running
      phaseCfg <= '{dirOut: 1'b1, width: sfpi_pkg::W_QUAD};
      txValid  <= 1'b1;
      sfpi_host_model_i.select(1'b0);
      sfpi_host_model_i.shift(1, 1'b1, 8'($random(seed)), got);
      intBusy   <= 1'b1;
      resetPinN <= 1'b0;
      waitCyc(32);
      check(16'(coreReset), 16'h1);
      check(16'(dataLineOeN), 16'hf);
      check(16'(selected), 16'h0);
      resetPinN <= 1'b1;
      intBusy   <= 1'b0;
      txValid   <= 1'b0;
      waitCyc(6);
      check(16'(coreReset), 16'h0);
      rxQ.delete();
      sfpi_host_model_i.shift(1, 1'b1, 8'h5a, got);
      waitCyc(6);
      check(16'(rxQ.size()), 16'h0);
      sfpi_host_model_i.deselect(1'b0);
      $display("test pin reset done");
      final_report();
   end
endmodule : sfpi_pin_front_tb_top

`default_nettype wire
